//--- standstill_monitor.v
// Purpose: standstill monitor with speed/position release, restart, mute, bypass, reset
// Assumes: sensor, referencing and handshake inputs are asynchronous pins
// Notes:   logic cycle is LOGIC_CYCLE_CLKS hclk periods; speed is counts per interval
`default_nettype none
`include "standstill_monitor_map.vh"
module standstill_monitor
#(
  parameter TWO_INPUTS_HW = 1,
  parameter CYCLE_CLKS    = `LOGIC_CYCLE_CLKS,
  parameter TOL_CYCLES    = 4
)
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        motion1_a,
  input  wire        motion1_b,
  input  wire        motion2_a,
  input  wire        motion2_b,
  input  wire        reference_in,
  input  wire        restart_in,
  input  wire        mute_in,
  input  wire        bypass_in,
  input  wire        reset_in,
  output reg         release_out,
  output reg         restart_required,
  output reg         reset_required,
  output reg  [8:0]  error_flags
);
  function signed [31:0] abs32;
    input signed [31:0] v;
    abs32 = v[31] ? -v : v;
  endfunction

  // two-stage synchronisers on every pin input
  localparam NS = 9;
  wire [NS-1:0] pin_raw = {reset_in, bypass_in, mute_in, restart_in, reference_in,
                           motion2_b, motion2_a, motion1_b, motion1_a};
  reg  [NS-1:0] sync1_r;
  reg  [NS-1:0] sync2_r;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= {NS{1'b0}};
      sync2_r <= {NS{1'b0}};
    end
    else
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  // AHB-Lite slave, zero wait, always OKAY
  reg  [31:0] ctrl_r, meas_r, tlim_r, spd_lim_r, pos_lo_r, pos_hi_r, ref_val_r, diff_r;
  reg  [7:0]  a_addr_r;
  reg         a_wr_r;
  wire        a_take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_addr_r <= 8'h00;
      a_wr_r <= 1'b0;
      ctrl_r <= `CTRL_RESET;
      meas_r <= `MEAS_MS_RESET;
      tlim_r <= `TLIM_S_RESET;
      spd_lim_r <= 32'h0000_0000;
      pos_lo_r <= 32'h0000_0000;
      pos_hi_r <= 32'h0000_0000;
      ref_val_r <= 32'h0000_0000;
      diff_r <= 32'h0000_0000;
    end
    else
    begin
      a_addr_r <= haddr[7:0];
      a_wr_r <= a_take && hwrite;
      if (a_wr_r)
      begin
        case (a_addr_r)
          `OFF_CTRL:    ctrl_r <= hwdata;
          // interval clamped into its legal range in whole ms
          `OFF_MEAS:    meas_r <= (hwdata == 32'h0) ? 32'h1 :
                                  (hwdata > `MEAS_MS_MAX) ? `MEAS_MS_MAX : hwdata;
          `OFF_TLIM:    tlim_r <= (hwdata < `TLIM_S_MIN) ? `TLIM_S_MIN :
                                  (hwdata > `TLIM_S_MAX) ? `TLIM_S_MAX : hwdata;
          `OFF_SPD_LIM: spd_lim_r <= hwdata;
          `OFF_POS_LO:  pos_lo_r <= hwdata;
          `OFF_POS_HI:  pos_hi_r <= hwdata;
          `OFF_REF_VAL: ref_val_r <= hwdata;
          `OFF_DIFF:    diff_r <= hwdata;
          default:      ;
        endcase
      end
    end
  end

  wire [1:0] mode      = ctrl_r[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
  wire       manual    = ctrl_r[`CTRL_RESTART_LSB+1:`CTRL_RESTART_LSB] == `RESTART_MANUAL;
  wire       two_in    = ctrl_r[`CTRL_TWO_IN] && (TWO_INPUTS_HW != 0);
  wire [6:0] hyst      = ctrl_r[`CTRL_HYST_LSB+6:`CTRL_HYST_LSB];
  wire [8:0] err_en    = ctrl_r[`CTRL_ERR_EN_LSB+8:`CTRL_ERR_EN_LSB];

  // logic-cycle tick and interval / time-limit counters
  reg  [31:0] cyc_cnt_r;
  reg  [31:0] meas_cnt_r;
  reg  [31:0] lim_cnt_r;
  wire        tick = cyc_cnt_r == CYCLE_CLKS - 1;
  wire        meas_end = tick && (meas_cnt_r >= meas_r - 32'h1);

  wire [31:0] d1, d2;
  wire        ph1, ph2;
  pulse_counter #(.W(32)) u_cnt1 (
    .hclk(hclk), .hresetn(hresetn), .enable(1'b1),
    .a(sync2_r[0]), .b(sync2_r[1]), .clear_delta(meas_end),
    .delta_r(d1), .phase_err_r(ph1));
  pulse_counter #(.W(32)) u_cnt2 (
    .hclk(hclk), .hresetn(hresetn), .enable(two_in),
    .a(sync2_r[2]), .b(sync2_r[3]), .clear_delta(meas_end),
    .delta_r(d2), .phase_err_r(ph2));

  reg  [31:0] speed_r, speed2_r, pos_r, pos2_r;
  reg         ref_prev_r, rst_prev_r, rst_high_r, rs_prev_r, rs_high_r;
  reg         spd_ok_r, pos_ok_r, mon_rel_r, granted_r, err_lock_r;
  reg  [31:0] tol_cnt_r;
  reg  [8:0]  err_pend_r;
  reg         phase_seen_r;

  // hysteresis: window shrinks by hyst percent while release is off
  wire signed [31:0] slim  = spd_lim_r;
  wire signed [31:0] s_sh  = (slim * $signed({25'h0, hyst})) / 100;
  wire signed [31:0] s_on  = mon_rel_r ? slim : slim - s_sh;
  wire signed [31:0] pspan = $signed(pos_hi_r) - $signed(pos_lo_r);
  wire signed [31:0] p_sh  = (pspan * $signed({25'h0, hyst})) / 100;
  wire signed [31:0] p_lo  = mon_rel_r ? $signed(pos_lo_r) : $signed(pos_lo_r) + p_sh;
  wire signed [31:0] p_hi  = mon_rel_r ? $signed(pos_hi_r) : $signed(pos_hi_r) - p_sh;
  wire signed [31:0] spd   = speed_r;
  wire spd_ok = ctrl_r[`CTRL_DIR_EN] ? (spd <= s_on && spd >= -s_on) : (spd <= s_on);
  wire signed [31:0] pos_s = pos_r;
  wire pos_ok = (pos_s >= p_lo) && (pos_s <= p_hi);
  wire spd_diff = two_in && ctrl_r[`CTRL_CMP_EN] &&
                  abs32($signed(speed_r) - $signed(speed2_r)) > $signed(diff_r);
  wire pos_diff = two_in && ctrl_r[`CTRL_CMP_EN] &&
                  abs32($signed(pos_r) - $signed(pos2_r)) > $signed(diff_r);
  wire cmp_bad = ((mode != `MODE_POS) && spd_diff) || ((mode != `MODE_SPD) && pos_diff);
  wire cmp_fail = tol_cnt_r >= TOL_CYCLES;
  reg  rel_now;
  always @*
  begin
    case (mode)
      `MODE_POS:  rel_now = pos_ok;
      `MODE_BOTH: rel_now = pos_ok && spd_ok;
      default:    rel_now = spd_ok;
    endcase
  end
  wire [8:0] err_now;
  assign err_now[`ERR_GENERAL]   = cmp_fail || phase_seen_r;
  assign err_now[`ERR_CUTOFF]    = 1'b0;
  assign err_now[`ERR_STUCK]     = 1'b0;
  assign err_now[`ERR_PHASE]     = phase_seen_r;
  assign err_now[`ERR_DISCREP]   = cmp_fail;
  assign err_now[`ERR_SPD_LIMIT] = (mode != `MODE_POS) && !spd_ok;
  assign err_now[`ERR_SPD_DIFF]  = cmp_fail && spd_diff;
  assign err_now[`ERR_POS_RANGE] = (mode != `MODE_SPD) && !pos_ok;
  assign err_now[`ERR_POS_DIFF]  = cmp_fail && pos_diff;
  wire fault = cmp_fail || phase_seen_r;
  wire mute_act = ctrl_r[`CTRL_MUTE_EN] && sync2_r[6] && release_out;
  wire byp_act  = ctrl_r[`CTRL_BYP_EN] && sync2_r[7];
  wire lim_hit  = ctrl_r[`CTRL_TLIM_EN] && (lim_cnt_r >= tlim_r * 32'd1000);
  wire rs_pulse = rs_high_r && !sync2_r[5] && rs_prev_r == 1'b0;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cyc_cnt_r <= 32'h0;
      meas_cnt_r <= 32'h0;
      lim_cnt_r <= 32'h0;
      speed_r <= 32'h0;
      speed2_r <= 32'h0;
      pos_r <= 32'h0;
      pos2_r <= 32'h0;
      ref_prev_r <= 1'b0;
      rst_prev_r <= 1'b0;
      rst_high_r <= 1'b0;
      rs_prev_r <= 1'b0;
      rs_high_r <= 1'b0;
      spd_ok_r <= 1'b0;
      pos_ok_r <= 1'b0;
      mon_rel_r <= 1'b0;
      granted_r <= 1'b0;
      err_lock_r <= 1'b0;
      tol_cnt_r <= 32'h0;
      err_pend_r <= 9'h0;
      phase_seen_r <= 1'b0;
      release_out <= 1'b0;
      restart_required <= 1'b0;
      reset_required <= 1'b0;
      error_flags <= 9'h0;
    end
    else
    begin
      cyc_cnt_r <= tick ? 32'h0 : cyc_cnt_r + 32'h1;
      if (ph1 || ph2)
        phase_seen_r <= 1'b1;
      if (meas_end)
      begin
        speed_r <= d1;
        speed2_r <= d2;
        pos_r <= pos_r + d1;
        pos2_r <= pos2_r + d2;
      end
      if (tick)
      begin
        meas_cnt_r <= meas_end ? 32'h0 : meas_cnt_r + 32'h1;
        phase_seen_r <= ph1 || ph2;
        ref_prev_r <= sync2_r[4];
        if (ctrl_r[`CTRL_REF_EN] && ref_prev_r && !sync2_r[4])
        begin
          pos_r <= ref_val_r;
          pos2_r <= ref_val_r;
        end
        tol_cnt_r <= cmp_bad ? (cmp_fail ? tol_cnt_r : tol_cnt_r + 32'h1) : 32'h0;
        // high-low (falling edge) detection, sampled once per logic cycle
        rs_prev_r <= rs_high_r;
        rs_high_r <= sync2_r[5];
        rst_prev_r <= rst_high_r;
        rst_high_r <= sync2_r[8];
        spd_ok_r <= spd_ok;
        pos_ok_r <= pos_ok;
        mon_rel_r <= rel_now && !err_lock_r && !fault;
        err_pend_r <= err_now & err_en;
        error_flags <= err_now & err_en;
        if (fault && !err_lock_r)
          err_lock_r <= 1'b1;
        else if (err_lock_r && !fault && rst_prev_r && !rst_high_r && !sync2_r[8])
          err_lock_r <= 1'b0;
        reset_required <= err_lock_r && !fault;
        // restart: waiting release needs acknowledgement in manual mode
        if (!(rel_now && !err_lock_r && !fault))
          granted_r <= 1'b0;
        else if (!manual || (rs_prev_r && !rs_high_r))
          granted_r <= 1'b1;
        restart_required <= manual && rel_now && !err_lock_r && !fault && !granted_r;
        if (mute_act || byp_act)
          lim_cnt_r <= lim_hit ? lim_cnt_r : lim_cnt_r + `LOGIC_CYCLE_US / 1000;
        else
          lim_cnt_r <= 32'h0;
        release_out <= (granted_r && mon_rel_r) ||
                       ((mute_act || byp_act) && !lim_hit);
      end
    end
  end

  reg [31:0] rd_r;
  always @*
  begin
    case (a_addr_r)
      `OFF_CTRL:    rd_r = ctrl_r;
      `OFF_MEAS:    rd_r = meas_r;
      `OFF_TLIM:    rd_r = tlim_r;
      `OFF_SPD_LIM: rd_r = spd_lim_r;
      `OFF_POS_LO:  rd_r = pos_lo_r;
      `OFF_POS_HI:  rd_r = pos_hi_r;
      `OFF_REF_VAL: rd_r = ref_val_r;
      `OFF_DIFF:    rd_r = diff_r;
      `OFF_STATUS:  rd_r = {26'h0, spd_ok_r, pos_ok_r, mon_rel_r, reset_required,
                            restart_required, release_out};
      `OFF_POS:     rd_r = pos_r;
      `OFF_SPEED:   rd_r = speed_r;
      `OFF_ERR:     rd_r = {23'h0, err_pend_r};
      default:      rd_r = 32'h0;
    endcase
  end
  assign hrdata = rd_r;
  wire unused_ok = &{1'b0, hsize, haddr[31:8], rs_pulse, a_take};
endmodule
`default_nettype wire

//--- standstill_monitor_map.vh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite word registers, 10 MHz hclk
// Notes:   included by the standstill monitor files
`ifndef STANDSTILL_MONITOR_MAP_VH
`define STANDSTILL_MONITOR_MAP_VH

`define CLK_HZ            10000000
`define LOGIC_CYCLE_US    1000
`define LOGIC_CYCLE_CLKS  ((`CLK_HZ / 1000000) * `LOGIC_CYCLE_US)

`define OFF_CTRL          8'h00
`define OFF_MEAS          8'h04
`define OFF_TLIM          8'h08
`define OFF_SPD_LIM       8'h0C
`define OFF_POS_LO        8'h10
`define OFF_POS_HI        8'h14
`define OFF_REF_VAL       8'h18
`define OFF_DIFF          8'h1C
`define OFF_STATUS        8'h20
`define OFF_POS           8'h24
`define OFF_SPEED         8'h28
`define OFF_ERR           8'h2C

`define CTRL_MODE_LSB     0
`define CTRL_RESTART_LSB  2
`define CTRL_REF_EN       4
`define CTRL_MUTE_EN      5
`define CTRL_BYP_EN       6
`define CTRL_TLIM_EN      7
`define CTRL_TWO_IN       8
`define CTRL_DIR_EN       9
`define CTRL_CMP_EN       10
`define CTRL_HYST_LSB     16
`define CTRL_ERR_EN_LSB   23

`define MODE_POS          2'h1
`define MODE_SPD          2'h2
`define MODE_BOTH         2'h3
`define RESTART_MANUAL    2'h1
`define RESTART_AUTO      2'h2

// mode 2, auto restart, time limit on, hysteresis 0, no error flags enabled
`define CTRL_RESET        32'h0000_008A
`define MEAS_MS_RESET     32'h0000_0004
`define TLIM_S_RESET      32'h0000_0001
`define TLIM_S_MIN        32'h0000_0001
`define TLIM_S_MAX        32'h0000_1C20
`define MEAS_MS_MAX       32'h0000_FFFC

`define NUM_ERR           9
`define ERR_GENERAL       0
`define ERR_CUTOFF        1
`define ERR_STUCK         2
`define ERR_PHASE         3
`define ERR_DISCREP       4
`define ERR_SPD_LIMIT     5
`define ERR_SPD_DIFF      6
`define ERR_POS_RANGE     7
`define ERR_POS_DIFF      8

`endif

//--- pulse_counter.v
// Purpose: per-sensor quadrature count of one motion input
// Assumes: a/b already synchronised to hclk
// Notes:   phase faults come from illegal transitions; no stuck fault is detected
`default_nettype none
module pulse_counter
#(
  parameter W = 32
)
(
  input  wire         hclk,
  input  wire         hresetn,
  input  wire         enable,
  input  wire         a,
  input  wire         b,
  input  wire         clear_delta,
  output reg  [W-1:0] delta_r,
  output reg          phase_err_r
);
  reg [1:0] prev_r;
  wire [1:0] cur = {a, b};
  wire       step = enable && (cur != prev_r);
  // gray step up: 00->01->11->10->00
  wire       up = (prev_r == 2'h0 && cur == 2'h1) || (prev_r == 2'h1 && cur == 2'h3) ||
                  (prev_r == 2'h3 && cur == 2'h2) || (prev_r == 2'h2 && cur == 2'h0);
  wire       bad = (prev_r ^ cur) == 2'h3;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_r <= 2'h0;
      delta_r <= {W{1'b0}};
      phase_err_r <= 1'b0;
    end
    else
    begin
      prev_r <= cur;
      phase_err_r <= step && bad;
      if (clear_delta)
        delta_r <= (step && !bad) ? (up ? {{(W-1){1'b0}}, 1'b1} : {W{1'b1}}) : {W{1'b0}};
      else if (step && !bad)
        delta_r <= up ? delta_r + {{(W-1){1'b0}}, 1'b1} : delta_r - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

//--- standstill_monitor_properties.sv
// Purpose: port-level properties of the standstill monitor
// Assumes: outputs move only on logic-cycle ticks at least 9 hclk apart
// Notes:   bound into every standstill_monitor instance
`default_nettype none
module standstill_monitor_properties
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       release_out,
  input wire logic       restart_required,
  input wire logic       reset_required,
  input wire logic [8:0] error_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_RESET_QUIET: assert property ($rose(hresetn) |-> !release_out && !reset_required)
    else $error("release or reset-required high right after reset");
  AST_RELEASE_TICK: assert property ($changed(release_out) |=> $stable(release_out)[*8])
    else $error("release moved between logic-cycle ticks");
  AST_RESTART_TICK: assert property ($changed(restart_required) |=> $stable(restart_required)[*8])
    else $error("restart-required moved between ticks");
  AST_RESETREQ_TICK: assert property ($changed(reset_required) |=> $stable(reset_required)[*8])
    else $error("reset-required moved between ticks");
  AST_FLAGS_TICK: assert property ($changed(error_flags) |=> $stable(error_flags)[*8])
    else $error("error flags moved between ticks");
  // a release still waiting for its acknowledgement must not be out yet
  AST_RESTART_WAIT: assert property (restart_required |-> !release_out)
    else $error("release high while restart is pending");
  AST_RESET_WAIT: assert property (reset_required |-> !release_out)
    else $error("release high while reset is pending");
  // cut-off and stuck faults cannot be seen at this level
  AST_UNSEEN_FLAGS: assert property (error_flags[2:1] == 2'b00)
    else $error("undetectable fault flag raised");

  COV_RELEASE_ON: cover property ($rose(release_out));
  COV_RELEASE_OFF: cover property ($fell(release_out));
  COV_RESTART_WAIT: cover property ($rose(restart_required));
  COV_RESET_WAIT: cover property ($rose(reset_required));
endmodule

bind standstill_monitor standstill_monitor_properties prop_u
(
  .hclk             (hclk),
  .hresetn          (hresetn),
  .release_out      (release_out),
  .restart_required (restart_required),
  .reset_required   (reset_required),
  .error_flags      (error_flags)
);
`default_nettype wire

//--- motion_sensor_model.sv
// Purpose: quadrature motion sensor stepping while told to run
// Assumes: one step every STEP+1 hclk, one fixed direction
// Notes:   at standstill the tracks hold their level, as a real encoder does
`default_nettype none
module motion_sensor_model
#(
  parameter int STEP = 19
)
(
  input  wire logic hclk,
  input  wire logic run,
  output var  logic a,
  output var  logic b
);
  timeunit 1ns;
  timeprecision 1ns;
  int         cnt = 0;
  logic [1:0] ph = 2'h0;

  always @(posedge hclk)
  begin
    if (!run)
      cnt <= 0;
    else if (cnt == STEP)
    begin
      cnt <= 0;
      ph <= ph + 2'h1;
    end
    else
      cnt <= cnt + 1;
  end
  // gray sequence keeps exactly one track changing per step
  assign a = ph[1];
  assign b = ph[1] ^ ph[0];
endmodule
`default_nettype wire

//--- test_standstill_monitor.sv
// Purpose: self-checking bench for the standstill monitor
// Assumes: zero-wait AHB-Lite slave, logic cycle shortened to CYC hclk
// Notes:   handshake pulses hold each level 4 ticks so edges are seen
`default_nettype none
`include "standstill_monitor_map.vh"
module test_standstill_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CYC = 10;
  logic        hclk, hresetn, hsel, hwrite, run, hreadyout, hresp, mot_a, mot_b;
  logic        reference_in, restart_in, mute_in, bypass_in, reset_in;
  logic        release_out, restart_required, reset_required;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [8:0]  error_flags;
  int          num_errors, samples_checked, cyc, n;

  motion_sensor_model sens_u (.hclk(hclk), .run(run), .a(mot_a), .b(mot_b));
  standstill_monitor #(.TWO_INPUTS_HW(1), .CYCLE_CLKS(CYC), .TOL_CYCLES(4)) dut_u
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .motion1_a(mot_a), .motion1_b(mot_b), .motion2_a(mot_a), .motion2_b(mot_b),
    .reference_in(reference_in), .restart_in(restart_in), .mute_in(mute_in),
    .bypass_in(bypass_in), .reset_in(reset_in), .release_out(release_out),
    .restart_required(restart_required), .reset_required(reset_required),
    .error_flags(error_flags)
  );

  always #50 hclk = ~hclk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic ticks(input int k);
    repeat (k * CYC) @(posedge hclk);
  endtask

  // waits for release (s=0) or restart-required (s=1) to reach v, then compares
  task automatic wait_out(input logic s, input logic v, input int lim);
    n = 0;
    while ((s ? restart_required : release_out) !== v && n < lim * CYC)
    begin
      @(posedge hclk);
      n++;
    end
    check(s ? "restart_req" : "release", 32'(s ? restart_required : release_out), 32'(v));
  endtask

  // sel 0 referencing, 1 restart, 2 reset
  task automatic lhl(input int sel);
    reference_in <= (sel == 0);
    restart_in <= (sel == 1);
    reset_in <= (sel == 2);
    ticks(4);
    {reference_in, restart_in, reset_in} <= '0;
    ticks(4);
  endtask

  task automatic t_defaults;
    logic [7:0]  ad [4] = '{`OFF_CTRL, `OFF_MEAS, `OFF_TLIM, 8'h30};
    logic [31:0] ev [4] = '{32'h0000_008A, 32'h4, 32'h1, 32'h0};
    for (int i = 0; i < 4; i++)
    begin
      ahb(1'b0, ad[i], 32'h0);
      check("reset_value", rd, ev[i]);
    end
  endtask

  task automatic t_clamp;
    logic [7:0]  ad [4] = '{`OFF_MEAS, `OFF_MEAS, `OFF_TLIM, `OFF_TLIM};
    logic [31:0] wv [4] = '{32'h0, 32'h0001_0000, 32'h0, 32'h0000_2000};
    logic [31:0] ev [4] = '{32'h1, `MEAS_MS_MAX, `TLIM_S_MIN, `TLIM_S_MAX};
    for (int i = 0; i < 4; i++)
    begin
      ahb(1'b1, ad[i], wv[i]);
      ahb(1'b0, ad[i], 32'h0);
      check("clamp", rd, ev[i]);
    end
    ahb(1'b1, `OFF_MEAS, 32'h4);
    ahb(1'b1, `OFF_TLIM, 32'h1);
  endtask

  task automatic t_reference;
    ahb(1'b1, `OFF_CTRL, 32'h0000_028A);
    ahb(1'b1, `OFF_REF_VAL, 32'h0000_1234);
    lhl(1'b0);
    ahb(1'b0, `OFF_POS, 32'h0);
    check("pos_ref_off", rd, 32'h0);
    ahb(1'b1, `OFF_CTRL, 32'h0000_029A);
    lhl(1'b0);
    ahb(1'b0, `OFF_POS, 32'h0);
    check("pos_ref_on", rd, 32'h0000_1234);
  endtask

  // position 0x1234 lies outside the window 0..0x10, speed is zero
  task automatic t_position;
    ahb(1'b1, `OFF_POS_LO, 32'h0);
    ahb(1'b1, `OFF_POS_HI, 32'h10);
    ahb(1'b1, `OFF_SPD_LIM, 32'h0);
    ahb(1'b1, `OFF_CTRL, 32'h0000_0299);
    wait_out(1'b0, 1'b0, 40);
    ahb(1'b1, `OFF_CTRL, 32'h0000_029A);
    wait_out(1'b0, 1'b1, 40);
    ahb(1'b1, `OFF_CTRL, 32'h0000_029B);
    wait_out(1'b0, 1'b0, 40);
    ahb(1'b1, `OFF_REF_VAL, 32'h8);
    lhl(1'b0);
    wait_out(1'b0, 1'b1, 40);
  endtask

  task automatic t_speed;
    ahb(1'b1, `OFF_CTRL, 32'h0000_028A);
    run <= 1'b1;
    wait_out(1'b0, 1'b0, 40);
    run <= 1'b0;
    wait_out(1'b0, 1'b1, 40);
    check("auto_no_wait", 32'(restart_required), 32'h0);
  endtask

  task automatic t_manual;
    ahb(1'b1, `OFF_CTRL, 32'h0000_0286);
    run <= 1'b1;
    wait_out(1'b0, 1'b0, 40);
    run <= 1'b0;
    wait_out(1'b1, 1'b1, 40);
    check("held", 32'(release_out), 32'h0);
    lhl(1'b1);
    wait_out(1'b0, 1'b1, 40);
    check("ack_done", 32'(restart_required), 32'h0);
  endtask

  task automatic t_mute;
    ahb(1'b1, `OFF_CTRL, 32'h0000_02AA);
    wait_out(1'b0, 1'b1, 40);
    mute_in <= 1'b1;
    ticks(2);
    run <= 1'b1;
    ticks(20);
    check("muted", 32'(release_out), 32'h1);
    mute_in <= 1'b0;
    wait_out(1'b0, 1'b0, 40);
    run <= 1'b0;
    wait_out(1'b0, 1'b1, 40);
  endtask

  // with 1 s limit and 1 ms logic cycle, bypass lasts 1000 ticks
  task automatic t_bypass;
    ahb(1'b1, `OFF_CTRL, 32'h0000_02CA);
    run <= 1'b1;
    wait_out(1'b0, 1'b0, 40);
    bypass_in <= 1'b1;
    wait_out(1'b0, 1'b1, 40);
    wait_out(1'b0, 1'b0, 1100);
    check("bypass_span", 32'(n >= 990 * CYC && n <= 1010 * CYC), 32'h1);
    bypass_in <= 1'b0;
    run <= 1'b0;
    wait_out(1'b0, 1'b1, 40);
  endtask

  // pos2 counted no motion while the second input was off, so the positions disagree
  task automatic t_fault;
    ahb(1'b1, `OFF_POS_HI, 32'h7FFF_FFFF);
    ahb(1'b1, `OFF_CTRL, 32'hFF80_0599);
    ticks(2);
    check("tolerance", 32'(release_out), 32'h1);
    wait_out(1'b0, 1'b0, 40);
    check("error_flags", 32'(error_flags), 32'h0000_0111);
    lhl(0);
    check("reset_req", 32'(reset_required), 32'h1);
    check("locked", 32'(release_out), 32'h0);
    lhl(2);
    wait_out(1'b0, 1'b1, 40);
    check("reset_done", 32'(reset_required), 32'h0);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // the bypass run dominates at about 10000 cycles
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      num_errors++;
      report_and_stop;
    end
  end

  initial
  begin
    {hclk, hresetn, hsel, hwrite, run, htrans, haddr, hwdata} = '0;
    {reference_in, restart_in, mute_in, bypass_in, reset_in} = '0;
    hsize = 3'b010;
    {num_errors, samples_checked} = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_defaults;
    t_clamp;
    t_reference;
    t_position;
    t_speed;
    t_manual;
    t_mute;
    t_bypass;
    t_fault;
    report_and_stop;
  end
endmodule
`default_nettype wire
